// >>> hdl/plm_pkg.sv
// Shared constants, link states and the state record of the port link manager.
package plm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and status-output timing.
	localparam int CLK_HZ        = 40_000_000;
	localparam int EXP_PERIOD_MS = 40;
	localparam int ACT_HOLD_MS   = 200;
	// Cycles between two expander updates; a longest spacing, rounded down.
	localparam int EXP_PERIOD_CYC = (EXP_PERIOD_MS * (CLK_HZ / 1000));
	// Expander periods the activity output stays asserted; rounded up.
	localparam int HOLD_TICKS_I =
		(ACT_HOLD_MS + EXP_PERIOD_MS - 1) / EXP_PERIOD_MS;
	localparam int EXP_CNT_W = 21;
	localparam logic [2:0] HOLD_TICKS = 3'(HOLD_TICKS_I);

	////////////////////////////////////////////////////////////////////////////
	// Field widths.
	localparam int ET_W     = 8;
	localparam int CRED_W   = 12;
	localparam int SCALE_W  = 8;
	localparam int VALUE_W  = 2;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset.
	localparam logic [ET_W-1:0]      TIMER_RST = 8'h00;
	localparam logic [EXP_CNT_W-1:0] TICK_RST  = 21'h000000;
	localparam logic [CRED_W-1:0]    CRED_RST  = 12'h000;
	localparam logic [SCALE_W-1:0]   SCALE_RST = 8'h00;
	localparam logic [VALUE_W-1:0]   VALUE_RST = 2'h0;

	// State reported by the physical layer training machine.
	typedef enum logic [2:0] {
		PLM_DETECT, PLM_POLLING, PLM_CONFIG, PLM_L0, PLM_L0S, PLM_L1,
		PLM_RECOVERY, PLM_OTHER
	} plm_ltssm_type;

	// Progress of an L1 request towards the partner.
	typedef enum logic [0:0] {PLM_L1_IDLE, PLM_L1_WAIT} plm_l1_type;

	// Whole state of one port.
	typedef struct packed {
		plm_l1_type              l1State;
		logic                    dlUp;
		logic                    wasRecov;
		logic                    highRate;
		logic                    holdLow;
		logic                    advHigh;
		logic                    goRecovery;
		logic                    goDetect;
		logic                    bwStatus;
		logic                    surpriseDn;
		logic                    dropQueued;
		logic                    urTarget;
		logic                    cfgDone;
		logic                    fcAdvertise;
		logic [CRED_W-1:0]       fcCredits;
		logic                    splSend;
		logic [SCALE_W-1:0]      capScale;
		logic [VALUE_W-1:0]      capValue;
		logic [ET_W-1:0]         l0sCnt;
		logic [ET_W-1:0]         l1Cnt;
		logic                    l0sEnter;
		logic                    l1Req;
		logic                    l1Enter;
		logic                    l0sFallback;
		logic [EXP_CNT_W-1:0]    tickCnt;
		logic [2:0]              holdTicks;
		logic                    actSeen;
		logic                    linkUpN;
		logic                    activeN;
	} plm_state_type;

	// Data link layer counts as up in these training states.
	function automatic logic plm_is_up(plm_ltssm_type s);
		return (s == PLM_L0) || (s == PLM_L0S) || (s == PLM_L1) ||
			(s == PLM_RECOVERY);
	endfunction

endpackage

// >>> hdl/plm_port_link_manager.sv
// Link management logic of one switch port: retraining, power states, status.
`timescale 1ns/1ps

module plm_port_link_manager #(
	parameter bit UPSTREAM      = 1'b0,
	parameter int EXP_CYC       = plm_pkg::EXP_PERIOD_CYC
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        retrainWr,
	input  wire logic                        fullRetrainWr,
	input  wire logic                        registerUnlock,
	input  plm_pkg::plm_ltssm_type           ltssmState,
	input  wire logic                        phyRateHigh,
	input  wire logic                        partnerUpgradeReq,
	input  wire logic                        alrHoldLow,
	input  wire logic                        bwStatusClr,
	input  wire logic                        surpriseCond,
	input  wire logic                        surpriseClr,
	input  wire logic                        cfgReq,
	input  wire logic [plm_pkg::CRED_W-1:0]  ifbSize,
	input  wire logic                        splRxValid,
	input  wire logic [15:0]                 splPayload,
	input  wire logic                        slotCapWr,
	input  wire logic                        aspmL0sEn,
	input  wire logic                        aspmL1En,
	input  wire logic [plm_pkg::ET_W-1:0]    l0sEntryTimer,
	input  wire logic [plm_pkg::ET_W-1:0]    l1EntryTimer,
	input  wire logic                        peerRxInL0s,
	input  wire logic                        allDnInL1,
	input  wire logic                        tlpPending,
	input  wire logic                        creditsAvail,
	input  wire logic                        dllpPending,
	input  wire logic                        l1Ack,
	input  wire logic                        l1Reject,
	input  wire logic                        tlpEvent,
	input  wire logic                        tlpIsVendorMsg,
	output wire logic                        ltssmGoRecovery,
	output wire logic                        ltssmGoDetect,
	output wire logic                        advertiseHighRate,
	output wire logic                        bandwidthMgmtStatus,
	output wire logic                        surpriseDownStatus,
	output wire logic                        dropQueuedTlp,
	output wire logic                        targetedUr,
	output wire logic                        cfgDone,
	output wire logic                        fcAdvertise,
	output wire logic [plm_pkg::CRED_W-1:0]  fcCredits,
	output wire logic                        splSend,
	output wire logic [plm_pkg::SCALE_W-1:0] capturedPowerScale,
	output wire logic [plm_pkg::VALUE_W-1:0] capturedPowerValue,
	output wire logic                        l0sEnter,
	output wire logic                        l1Request,
	output wire logic                        l1Enter,
	output wire logic                        l0sFallback,
	output wire logic                        port_link_up_n,
	output wire logic                        port_activity_n
);
	import plm_pkg::*;

	plm_state_type st_r;
	plm_state_type st_nxt;
	logic          upNow;
	logic          txIdle;
	logic          l0sCond;
	logic          l1Cond;
	logic          tick;

	////////////////////////////////////////////////////////////////////////////
	// Qualifying conditions, combinational from the port inputs; tick decodes the registered tick counter.
	assign upNow  = plm_is_up(ltssmState);
	assign txIdle = (!tlpPending || !creditsAvail) &&
		!dllpPending;
	// The peer receiver input means all active downstream ports on the
	// upstream port and the upstream port on a downstream port.
	assign l0sCond = aspmL0sEn && (ltssmState == PLM_L0) && peerRxInL0s &&
		txIdle;
	assign l1Cond = UPSTREAM && aspmL1En && allDnInL1 && txIdle &&
		((ltssmState == PLM_L0) || (ltssmState == PLM_L0S));
	assign tick = (st_r.tickCnt == EXP_CNT_W'(EXP_CYC - 1));

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole port.
	always_comb begin
		st_nxt = st_r;
		st_nxt.goRecovery  = retrainWr &&
			(!UPSTREAM || registerUnlock);
		st_nxt.goDetect    = fullRetrainWr;
		st_nxt.cfgDone     = cfgReq;
		st_nxt.fcAdvertise = 1'b0;
		st_nxt.splSend     = 1'b0;
		st_nxt.l0sEnter    = 1'b0;
		st_nxt.l1Enter     = 1'b0;
		st_nxt.l0sFallback = 1'b0;

		// Recovery keeps the link up; only a pass through the down states
		// such as Detect brings it down.
		st_nxt.dlUp       = upNow;
		st_nxt.dropQueued = !upNow;
		st_nxt.urTarget   = !upNow;

		// Link coming up: load credits and, on a downstream port only, announce the slot power limit.
		if (upNow && !st_r.dlUp) begin
			st_nxt.fcAdvertise = 1'b1;
			st_nxt.fcCredits   = ifbSize;
			st_nxt.splSend     = !UPSTREAM;
		end
		if (!UPSTREAM && slotCapWr && st_r.dlUp) begin
			st_nxt.splSend = 1'b1;
		end

		// Surprise down: the set wins over a clear in the same cycle.
		if (surpriseClr) begin
			st_nxt.surpriseDn = 1'b0;
		end
		if (!UPSTREAM && st_r.dlUp && !upNow && surpriseCond) begin
			st_nxt.surpriseDn = 1'b1;
		end

		// Power limit capture on the upstream port.
		if (UPSTREAM && splRxValid) begin
			st_nxt.capScale = splPayload[7:0];
			st_nxt.capValue = splPayload[9:8];
		end

		// Rate tracking after retraining; the check runs when Recovery ends.
		if (ltssmState == PLM_RECOVERY) begin
			st_nxt.wasRecov = 1'b1;
		end
		if (bwStatusClr) begin
			st_nxt.bwStatus = 1'b0;
		end
		if (ltssmState == PLM_L0) begin
			st_nxt.highRate = phyRateHigh;
			st_nxt.wasRecov = 1'b0;
			if (st_r.wasRecov && st_r.highRate && !phyRateHigh) begin
				st_nxt.holdLow  = 1'b1;
				st_nxt.advHigh  = 1'b0;
				st_nxt.bwStatus = !UPSTREAM || st_r.bwStatus;
			end
		end
		// The reliability hold may veto a partner upgrade, not a retrain.
		if (retrainWr || fullRetrainWr ||
			(partnerUpgradeReq && !alrHoldLow)) begin
			st_nxt.holdLow = 1'b0;
			st_nxt.advHigh = 1'b1;
		end

		// L0s entry timer: any broken condition restarts the count.
		if (!l0sCond) begin
			st_nxt.l0sCnt = TIMER_RST;
		end else if (st_r.l0sCnt >= l0sEntryTimer) begin
			st_nxt.l0sEnter = 1'b1;
			st_nxt.l0sCnt   = TIMER_RST;
		end else begin
			st_nxt.l0sCnt = st_r.l0sCnt + 1'b1;
		end

		// L1 entry timer and handshake with the partner.
		unique case (st_r.l1State)
			PLM_L1_IDLE: begin
				if (!l1Cond) begin
					st_nxt.l1Cnt = TIMER_RST;
				end else if (st_r.l1Cnt >= l1EntryTimer) begin
					st_nxt.l1Req   = 1'b1;
					st_nxt.l1Cnt   = TIMER_RST;
					st_nxt.l1State = PLM_L1_WAIT;
				end else begin
					st_nxt.l1Cnt = st_r.l1Cnt + 1'b1;
				end
			end
			PLM_L1_WAIT: begin
				// The partner answers every request with one of the two.
				if (l1Ack) begin
					st_nxt.l1Req   = 1'b0;
					st_nxt.l1Enter = 1'b1;
					st_nxt.l1State = PLM_L1_IDLE;
				end else if (l1Reject) begin
					st_nxt.l1Req       = 1'b0;
					st_nxt.l0sFallback = 1'b1;
					st_nxt.l1State     = PLM_L1_IDLE;
				end
			end
		endcase

		// Status outputs change only on expander update ticks, so a short
		// burst of traffic is stretched rather than lost.
		st_nxt.tickCnt = tick ? TICK_RST : st_r.tickCnt + 1'b1;
		if (tlpEvent && !tlpIsVendorMsg) begin
			st_nxt.actSeen = 1'b1;
		end
		if (tick) begin
			st_nxt.linkUpN = !st_r.dlUp;
			if (st_r.actSeen) begin
				st_nxt.activeN   = 1'b0;
				st_nxt.holdTicks = HOLD_TICKS;
				st_nxt.actSeen   = tlpEvent && !tlpIsVendorMsg;
			end else if (st_r.holdTicks > 3'h1) begin
				st_nxt.holdTicks = st_r.holdTicks - 3'h1;
			end else begin
				st_nxt.activeN   = 1'b1;
				st_nxt.holdTicks = 3'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r <= '{l1State: PLM_L1_IDLE, advHigh: 1'b1, linkUpN: 1'b1,
				activeN: 1'b1, dropQueued: 1'b1, urTarget: 1'b1,
				fcCredits: CRED_RST, capScale: SCALE_RST,
				capValue: VALUE_RST, l0sCnt: TIMER_RST, l1Cnt: TIMER_RST,
				tickCnt: TICK_RST, holdTicks: 3'h0, default: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Every output is a field of the state register.
	assign ltssmGoRecovery     = st_r.goRecovery;
	assign ltssmGoDetect       = st_r.goDetect;
	assign advertiseHighRate   = st_r.advHigh;
	assign bandwidthMgmtStatus = st_r.bwStatus;
	assign surpriseDownStatus  = st_r.surpriseDn;
	assign dropQueuedTlp       = st_r.dropQueued;
	assign targetedUr          = st_r.urTarget;
	assign cfgDone             = st_r.cfgDone;
	assign fcAdvertise         = st_r.fcAdvertise;
	assign fcCredits           = st_r.fcCredits;
	assign splSend             = st_r.splSend;
	assign capturedPowerScale  = st_r.capScale;
	assign capturedPowerValue  = st_r.capValue;
	assign l0sEnter            = st_r.l0sEnter;
	assign l1Request           = st_r.l1Req;
	assign l1Enter             = st_r.l1Enter;
	assign l0sFallback         = st_r.l0sFallback;
	assign port_link_up_n      = st_r.linkUpN;
	assign port_activity_n     = st_r.activeN;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the behaviour above.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence l1Asked;
		st_r.l1Req && (st_r.l1State == PLM_L1_WAIT);
	endsequence
	sequence l1Granted;
		l1Asked ##0 l1Ack;
	endsequence
	sequence l1Denied;
		l1Asked ##0 (!l1Ack && l1Reject);
	endsequence

	AST_RETRAIN_GO: assert property (
		retrainWr && (!UPSTREAM || registerUnlock) |=> ltssmGoRecovery)
		else $error("Retrain write did not start Recovery.");
	AST_RETRAIN_LOCKED: assert property (
		UPSTREAM && retrainWr && !registerUnlock |=> !ltssmGoRecovery)
		else $error("Locked upstream retrain started Recovery.");
	AST_FULL_RETRAIN: assert property (
		fullRetrainWr |=> ltssmGoDetect)
		else $error("Full retrain did not go to Detect.");
	AST_BW_UPSTREAM: assert property (
		UPSTREAM |-> !bandwidthMgmtStatus)
		else $error("Upstream port set bandwidth status.");
	AST_LINK_LOSS: assert property (
		$fell(st_r.dlUp) |-> dropQueuedTlp && targetedUr)
		else $error("Link down without discard and unsupported handling.");
	AST_CFG_DONE: assert property (
		cfgReq |=> cfgDone)
		else $error("Configuration access not completed.");
	AST_SPL_CAPTURE: assert property (
		UPSTREAM && splRxValid |=>
		capturedPowerScale == $past(splPayload[7:0]) &&
		capturedPowerValue == $past(splPayload[9:8]))
		else $error("Power limit not captured.");
	AST_L1_UPSTREAM: assert property (
		!UPSTREAM |-> !l1Request)
		else $error("Downstream port requested L1.");
	AST_L1_GRANT: assert property (
		l1Granted |=> l1Enter && !l1Request)
		else $error("Acknowledged L1 not entered.");
	AST_L1_DENY: assert property (
		l1Denied |=> l0sFallback && !l1Enter)
		else $error("Rejected L1 did not fall back to L0s.");
	AST_L0S_TIMER: assert property (
		!l0sCond |=> st_r.l0sCnt == TIMER_RST && !l0sEnter)
		else $error("L0s timer did not restart.");
	AST_ACT_HOLD: assert property (
		tick && st_r.actSeen |=>
		!port_activity_n && st_r.holdTicks == HOLD_TICKS)
		else $error("Activity output not asserted with full hold.");

endmodule // plm_port_link_manager

// >>> tb/plm_link_partner.sv
// Behavioural link partner that answers the L1 requests of the upstream port.
`timescale 1ns/1ps

module plm_link_partner (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       l1Request,
	input  wire logic       ackMode,
	input  wire logic [3:0] delay,
	output logic            l1Ack,
	output logic            l1Reject
);

	////////////////////////////////////////////////////////////////////////////
	// Each request gets exactly one answer after the chosen delay; a silent
	// partner would leave the port waiting forever, which nothing here tests.
	initial begin
		l1Ack = 1'b0;
		l1Reject = 1'b0;
		forever begin
			@(negedge core_clk);
			if (!reset && l1Request) begin
				repeat (delay) @(negedge core_clk);
				l1Ack = ackMode;
				l1Reject = !ackMode;
				@(negedge core_clk);
				l1Ack = 1'b0;
				l1Reject = 1'b0;
				while (l1Request) @(negedge core_clk);
			end
		end
	end

endmodule // plm_link_partner

// >>> tb/plm_port_link_manager_test.sv
// Self-checking bench for a downstream and an upstream port link manager.
`timescale 1ns/1ps

module plm_port_link_manager_test;
	import plm_pkg::*;

	localparam int EXP  = 8;
	localparam int HOLD = ACT_HOLD_MS / EXP_PERIOD_MS;

	logic core_clk, reset, retrainWr, fullRetrainWr, registerUnlock;
	logic phyRateHigh, partnerUpgradeReq, alrHoldLow, bwStatusClr;
	logic surpriseCond, surpriseClr, cfgReq, splRxValid, slotCapWr;
	logic aspmL0sEn, aspmL1En, peerRxInL0s, allDnInL1, tlpPending;
	logic creditsAvail, dllpPending, l1Ack, l1Reject, tlpEvent;
	logic tlpIsVendorMsg, ackMode, ltssmGoRecovery, ltssmGoDetect;
	logic advertiseHighRate, bandwidthMgmtStatus, surpriseDownStatus;
	logic dropQueuedTlp, targetedUr, cfgDone, fcAdvertise, splSend;
	logic l0sEnter, l1Request, l1Enter, l0sFallback;
	logic port_link_up_n, port_activity_n, upBw, upAdv;
	logic upSurp, upDrop, upUr, upSpl, upLinkN;
	plm_ltssm_type      ltssmState;
	logic [CRED_W-1:0]  ifbSize, fcCredits;
	logic [15:0]        splPayload;
	logic [ET_W-1:0]    l0sEntryTimer, l1EntryTimer;
	logic [SCALE_W-1:0] capturedPowerScale, upScale;
	logic [VALUE_W-1:0] capturedPowerValue, upValue;
	logic [3:0]         delay;
	logic [19:0]        ev;
	logic [19:0]        notes[$];
	wire logic [4:0]    upEv;
	int                 errCount, testsRun, low;

	plm_port_link_manager #(.UPSTREAM(1'b0), .EXP_CYC(EXP)) u_dut (.*);

	// The upstream copy shares every input; its events land in upEv.
	plm_port_link_manager #(.UPSTREAM(1'b1), .EXP_CYC(EXP)) u_up (.*,
		.ltssmGoRecovery(upEv[4]), .ltssmGoDetect(upEv[3]),
		.l1Request(upEv[2]), .l1Enter(upEv[1]), .l0sFallback(upEv[0]),
		.advertiseHighRate(upAdv), .bandwidthMgmtStatus(upBw),
		.capturedPowerScale(upScale), .capturedPowerValue(upValue),
		.surpriseDownStatus(upSurp), .dropQueuedTlp(upDrop),
		.targetedUr(upUr), .splSend(upSpl), .port_link_up_n(upLinkN),
		.cfgDone(), .fcAdvertise(), .fcCredits(), .l0sEnter(),
		.port_activity_n());

	plm_link_partner u_partner (.core_clk(core_clk), .reset(reset),
		.l1Request(upEv[2]), .ackMode(ackMode), .delay(delay),
		.l1Ack(l1Ack), .l1Reject(l1Reject));

	////////////////////////////////////////////////////////////////////////////
	// Clock of 25 ns.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, exp, input string what);
		testsRun++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD %0t %s: saw %0h want %0h", $time, what, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask

	// Collects upstream events over n cycles; the retrain strobes are lowered
	// here so that a caller may raise one just before entering.
	task automatic seeUp(input int n, input logic [4:0] mask, want,
		input string what);
		logic [4:0] seen;
		seen = 5'h00;
		repeat (n) begin
			@(negedge core_clk);
			{retrainWr, fullRetrainWr} = 2'h0;
			seen = seen | upEv;
		end
		check(seen & mask, want, what);
	endtask

	// Counts the cycles in which the activity output is asserted.
	task automatic countLow(input int n);
		low = 0;
		repeat (n) begin
			@(negedge core_clk);
			low += int'(port_activity_n === 1'b0);
		end
	endtask

	task automatic wrapUp();
		$display("Checks made %0d, mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Each downstream event pulse takes the oldest note off the queue.
	always @(negedge core_clk) begin
		ev = {ltssmGoRecovery, ltssmGoDetect, splSend, fcAdvertise, l0sEnter,
			l1Enter, l0sFallback, cfgDone, fcAdvertise ? fcCredits : 12'h000};
		if (!reset && ev[19:12] != 8'h00) begin
			if (notes.size() == 0) check(ev, 20'h00000, "unexpected event");
			else check(ev, notes.pop_front(), "event");
		end
		// The upstream port never announces a slot power limit.
		if (!reset && upSpl) begin
			check(upSpl, 1'b0, "upstream power limit send");
		end
	end

	// A hang ends the run as a failure.
	initial begin
		cyc(4000);
		errCount++;
		$display("BAD %0t watchdog expired", $time);
		wrapUp();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(54789));
		{retrainWr, fullRetrainWr, registerUnlock, phyRateHigh} = 4'h0;
		{partnerUpgradeReq, alrHoldLow, bwStatusClr, surpriseCond} = 4'h0;
		{surpriseClr, cfgReq, splRxValid, slotCapWr, aspmL0sEn} = 5'h00;
		{aspmL1En, peerRxInL0s, allDnInL1, tlpPending, dllpPending} = 5'h00;
		{creditsAvail, tlpEvent, tlpIsVendorMsg, ackMode} = 4'h0;
		{ifbSize, splPayload, l0sEntryTimer, l1EntryTimer} = 44'h0;
		ltssmState = PLM_DETECT;
		delay = 4'h2;
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		check({advertiseHighRate, dropQueuedTlp, targetedUr, port_link_up_n,
			port_activity_n, bandwidthMgmtStatus}, 6'h3E, "reset");
		notes.push_back(20'h01000);
		pulse(cfgReq);
		phyRateHigh = 1'b1;
		ifbSize = 12'($urandom_range(1, 4095));
		notes.push_back({8'h30, ifbSize});
		ltssmState = PLM_L0;
		cyc(2);
		check({dropQueuedTlp, targetedUr}, 2'h0, "link up");
		cyc(EXP + 1);
		check({port_link_up_n, upLinkN}, 2'h0, "up status");
		notes.push_back(20'h80000);
		retrainWr = 1'b1;
		seeUp(3, 5'h10, 5'h00, "locked retrain");
		registerUnlock = 1'b1;
		notes.push_back(20'h80000);
		retrainWr = 1'b1;
		seeUp(3, 5'h10, 5'h10, "unlocked retrain");
		notes.push_back(20'h40000);
		fullRetrainWr = 1'b1;
		seeUp(3, 5'h08, 5'h08, "full retrain");
		for (int r = 1; r >= 0; r--) begin
			ltssmState = PLM_RECOVERY;
			cyc(2);
			check(dropQueuedTlp, 1'b0, "recovery not down");
			phyRateHigh = r[0];
			ltssmState = PLM_L0;
			cyc(2);
			check({advertiseHighRate, upAdv}, {2{r[0]}}, "rate");
			check({bandwidthMgmtStatus, upBw}, {!r[0], 1'b0}, "bw");
		end
		pulse(bwStatusClr);
		check(bandwidthMgmtStatus, 1'b0, "bw clear");
		alrHoldLow = 1'b1;
		pulse(partnerUpgradeReq);
		cyc(2);
		check(advertiseHighRate, 1'b0, "vetoed upgrade");
		alrHoldLow = 1'b0;
		pulse(partnerUpgradeReq);
		cyc(2);
		check(advertiseHighRate, 1'b1, "partner upgrade");
		splPayload = 16'($urandom());
		pulse(splRxValid);
		cyc(1);
		check({upScale, upValue}, {splPayload[7:0], splPayload[9:8]},
			"captured");
		check({capturedPowerScale, capturedPowerValue}, 10'h000,
			"not captured");
		notes.push_back(20'h20000);
		pulse(slotCapWr);
		// An interrupted interval must not count towards L0s entry.
		l0sEntryTimer = 8'($urandom_range(5, 12));
		{aspmL0sEn, peerRxInL0s, creditsAvail} = 3'h7;
		cyc(l0sEntryTimer - 1);
		pulse(dllpPending);
		notes.push_back(20'h08000);
		cyc(l0sEntryTimer + 6);
		{aspmL0sEn, tlpPending, aspmL1En} = 3'h3;
		cyc(2);
		check(notes.size(), 0, "l0s entry");
		// Only the upstream port asks; the partner acks, then rejects.
		tlpPending = 1'b0;
		l1EntryTimer = 8'($urandom_range(6, 20));
		seeUp(l1EntryTimer + 6, 5'h04, 5'h00, "l1 without peers");
		for (int k = 1; k >= 0; k--) begin
			ackMode = k[0];
			delay = 4'($urandom_range(0, 6));
			allDnInL1 = 1'b1;
			seeUp(l1EntryTimer + delay + 8, 5'h07, {1'b1, k[0], !k[0]},
				"l1 handshake");
			allDnInL1 = 1'b0;
			cyc(2);
		end
		check(l1Request, 1'b0, "downstream l1");
		tlpIsVendorMsg = 1'b1;
		pulse(tlpEvent);
		countLow(3 * EXP);
		check(low, 0, "vendor traffic");
		tlpIsVendorMsg = 1'b0;
		pulse(tlpEvent);
		countLow(8 * EXP);
		check(low, HOLD * EXP, "activity hold");
		// A clear in the cycle of the link loss must lose to the set.
		surpriseCond = 1'b1;
		surpriseClr = 1'b1;
		ltssmState = PLM_DETECT;
		cyc(1);
		surpriseClr = 1'b0;
		cyc(1);
		check({surpriseDownStatus, dropQueuedTlp, targetedUr, upSurp, upDrop,
			upUr}, 6'h3B, "link down");
		cyc(EXP + 1);
		check({port_link_up_n, upLinkN}, 2'h3, "down status");
		pulse(surpriseClr);
		check(surpriseDownStatus, 1'b0, "surprise clear");
		pulse(slotCapWr);
		notes.push_back(20'h01000);
		pulse(cfgReq);
		ifbSize = 12'($urandom_range(1, 4095));
		notes.push_back({8'h30, ifbSize});
		ltssmState = PLM_L0;
		cyc(4);
		check(notes.size(), 0, "all events seen");
		wrapUp();
	end

endmodule // plm_port_link_manager_test
